// *** src/mdsst_regs.svh ***
// mdsst_regs.svh: timing counts and command codes of the motion drive start/stop block
// assumes: included by bare name from the package and the self-checking bench
`ifndef MDSST_REGS_SVH
`define MDSST_REGS_SVH

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define MDSST_RESET_HOLD_CYC 4
`define MDSST_OUT_DEFINED_CYC 4
`define MDSST_SCLK_START_CYC 4'h2
`define MDSST_BUSY_RESET_CYC 4'h8
`define MDSST_BUSY_WRITE_SCLK 2'h2
`define MDSST_DIR_DELAY_SCLK 2'h1
`define MDSST_PULSE_DELAY_SCLK 2'h3
`define MDSST_MIN_STOP_TICKS 9'h002

// ----------------------------------------------------------------
// command codes on host_cmd_i
// ----------------------------------------------------------------
`define MDSST_CMD_FIX_PLUS 4'h0
`define MDSST_CMD_FIX_MINUS 4'h1
`define MDSST_CMD_CONT_PLUS 4'h2
`define MDSST_CMD_CONT_MINUS 4'h3
`define MDSST_CMD_HOLD 4'h4
`define MDSST_CMD_RELEASE 4'h5
`define MDSST_CMD_DECEL_STOP 4'h6
`define MDSST_CMD_SUDDEN_STOP 4'h7
`define MDSST_CMD_WRITE_OUT 4'h8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MDSST_OUT_DATA_RESET 8'h00

`endif

// *** src/mdsst_pkg.sv ***
// mdsst_pkg.sv: types shared by the motion drive start/stop modules
// assumes: mdsst_regs.svh sits on the include path
`include "mdsst_regs.svh"

package mdsst_pkg;
  typedef logic [3:0] mdsst_cmd_t;
  typedef enum logic [1:0] {
    MDSST_IDLE,
    MDSST_WAIT,
    MDSST_RUN
  } mdsst_axis_state_e;
endpackage : mdsst_pkg

// *** src/mdsst_axis_if.sv ***
// mdsst_axis_if.sv: link between the shared front end and one axis pulse engine
// assumes: both ends run on ref_clk_i
`timescale 1ns/1ps
`default_nettype none

interface mdsst_axis_if #(
  parameter int CW = 16
);
  logic tick;
  logic load;
  logic go;
  logic dir_minus;
  logic contin;
  logic [CW-1:0] count;
  logic [7:0] half;
  logic sudden;
  logic decel;
  logic [1:0] lim;
  logic lim_sudden;
  logic pulse_p;
  logic pulse_m;
  logic step;
  logic dir;
  logic driving;
  logic accel;
  logic decel_st;

  modport front (
    output tick, load, go, dir_minus, contin, count, half, sudden, decel, lim, lim_sudden,
    input pulse_p, pulse_m, step, dir, driving, accel, decel_st
  );
  modport axis (
    input tick, load, go, dir_minus, contin, count, half, sudden, decel, lim, lim_sudden,
    output pulse_p, pulse_m, step, dir, driving, accel, decel_st
  );
endinterface : mdsst_axis_if

`default_nettype wire

// *** src/mdsst_axis.sv ***
// mdsst_axis.sv: one axis pulse engine with start delays, ramp status and stops
// assumes: tick is a one-cycle strobe on each system clock rising edge
`timescale 1ns/1ps
`default_nettype none

module mdsst_axis
  import mdsst_pkg::*;
#(
  parameter int CW = 16,
  parameter logic [CW-1:0] RAMP_PULSES = 'h4
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  mdsst_axis_if.axis ax
);
  mdsst_axis_state_e state;
  logic [1:0] dly;
  logic [7:0] phase;
  logic hi;
  logic dminus;
  logic cont;
  logic dec_mode;
  logic [CW-1:0] target;
  logic [CW-1:0] sent;
  logic [CW-1:0] dec_left;

  wire [1:0] next_dly = 2'(dly + 2'h1);
  wire [7:0] next_phase = 8'(phase + 8'h01);
  wire half_done = (next_phase >= ax.half);
  wire lim_hit = dminus ? ax.lim[1] : ax.lim[0];
  wire stop_now = ax.sudden | (lim_hit & ax.lim_sudden);
  wire stop_slow = ax.decel | (lim_hit & ~ax.lim_sudden);
  wire [CW-1:0] remain = CW'(target - sent);
  wire count_done = ~cont & (sent >= target);
  wire slow_done = dec_mode & (dec_left == '0);
  wire finish = count_done | slow_done;
  wire near_end = ~cont & (remain < RAMP_PULSES);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= MDSST_IDLE;
      dly <= 2'h0;
      phase <= 8'h00;
      hi <= 1'b0;
      dminus <= 1'b0;
      cont <= 1'b0;
      dec_mode <= 1'b0;
      target <= '0;
      sent <= '0;
      dec_left <= '0;
      ax.pulse_p <= 1'b0;
      ax.pulse_m <= 1'b0;
      ax.step <= 1'b0;
      ax.dir <= 1'b0;
      ax.driving <= 1'b0;
      ax.accel <= 1'b0;
      ax.decel_st <= 1'b0;
    end else begin
      if (ax.load) begin
        dminus <= ax.dir_minus;
        cont <= ax.contin;
        target <= ax.count;
      end
      case (state)
        MDSST_IDLE: begin
          if (ax.go) begin
            state <= MDSST_WAIT;
            dly <= 2'h0;
            sent <= '0;
            dec_mode <= 1'b0;
            ax.driving <= 1'b1;
          end
        end
        MDSST_WAIT: begin
          if (ax.tick && stop_now) begin
            state <= MDSST_IDLE;
            ax.driving <= 1'b0;
          end else if (ax.tick) begin
            dly <= next_dly;
            if (next_dly == `MDSST_DIR_DELAY_SCLK) begin
              ax.dir <= dminus;
            end
            if (next_dly == `MDSST_PULSE_DELAY_SCLK) begin
              state <= MDSST_RUN;
              phase <= 8'h00;
              hi <= 1'b1;
              sent <= CW'(1);
              ax.pulse_p <= ~dminus;
              ax.pulse_m <= dminus;
              ax.step <= 1'b1;
              ax.accel <= (RAMP_PULSES != '0);
              ax.decel_st <= 1'b0;
            end
          end
        end
        MDSST_RUN: begin
          if (ax.tick && stop_now) begin
            state <= MDSST_IDLE;
            hi <= 1'b0;
            ax.pulse_p <= 1'b0;
            ax.pulse_m <= 1'b0;
            ax.step <= 1'b0;
            ax.driving <= 1'b0;
            ax.accel <= 1'b0;
            ax.decel_st <= 1'b0;
          end else if (ax.tick) begin
            if (stop_slow && !dec_mode) begin
              dec_mode <= 1'b1;
              dec_left <= RAMP_PULSES;
            end
            phase <= half_done ? 8'h00 : next_phase;
            if (half_done && hi) begin
              hi <= 1'b0;
              ax.pulse_p <= 1'b0;
              ax.pulse_m <= 1'b0;
              ax.step <= 1'b0;
            end else if (half_done && finish) begin
              state <= MDSST_IDLE;
              ax.driving <= 1'b0;
              ax.accel <= 1'b0;
              ax.decel_st <= 1'b0;
            end else if (half_done) begin
              hi <= 1'b1;
              sent <= CW'(sent + CW'(1));
              if (dec_mode) begin
                dec_left <= CW'(dec_left - CW'(1));
              end
              ax.pulse_p <= ~dminus;
              ax.pulse_m <= dminus;
              ax.step <= 1'b1;
              ax.accel <= ~dec_mode & ~near_end & (sent < RAMP_PULSES);
              ax.decel_st <= dec_mode | near_end;
            end
          end
        end
        default: begin
          state <= MDSST_IDLE;
        end
      endcase
    end
  end
endmodule : mdsst_axis

`default_nettype wire

// *** src/mdsst_top.sv ***
// mdsst_top.sv: two-axis drive start/stop timing, reset sequencing and busy handshake
// assumes: host pins and machine inputs are asynchronous; host holds cmd/data during a write
// Notes on behaviour
// - every output reaches its reset level within 4 master clock cycles of reset.
// - the system clock stays still in reset and starts 2 master cycles after release.
// - busy stays active for 8 master cycles after reset release.
// - a fixed or continuous drive emits its first pulse 3 system clocks after busy ends.
// - in step plus direction mode the direction is valid 1 system clock after busy ends.
// - driving status rises as busy ends and falls when the final pulse cycle completes.
// - accel and decel status are valid 3 system clocks after busy ends and drop at the end.
// - held axes released together raise driving at busy end and pulse 3 system clocks later.
// - emergency, sudden-mode limit, servo alarm or sudden command stop pulses at once.
// - stop inputs shorter than one system clock are not acted on.
// - stop inputs are sampled on the system clock rising edge.
// - an enabled filter delays stop recognition by the selected time constant.
// - stop inputs, decel-mode limits or the decel command start a decelerating stop.
// - input pins other than limits and emergency stop are readable in status registers and general outputs follow written data.
// - busy is active at most 2 system clocks after each write and the host waits meanwhile.
// - pulse, direction and status outputs change only on system clock rising edges.
`timescale 1ns/1ps
`default_nettype none

module mdsst_top
  import mdsst_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic host_wr_i,
  input wire logic [1:0] host_axis_i,
  input wire logic [3:0] host_cmd_i,
  input wire logic [15:0] host_data_i,
  input wire logic [7:0] speed_half_i,
  input wire logic step_mode_i,
  input wire logic [1:0] limit_sudden_i,
  input wire logic [5:0] stop_enable_i,
  input wire logic [1:0] alarm_enable_i,
  input wire logic filter_enable_i,
  input wire logic [2:0] filter_const_i,
  input wire logic emergency_stop_in_n,
  input wire logic [3:0] limit_plus_minus_in,
  input wire logic [1:0] servo_alarm_in,
  input wire logic [5:0] stop_inputs,
  input wire logic [11:0] general_inputs,
  input wire logic [1:0] ext_jog_plus_in,
  input wire logic [1:0] ext_jog_minus_in,
  input wire logic [1:0] in_position_in,
  output logic sclk_o,
  output logic busy_out_n,
  output logic busy_oe_o,
  output logic [1:0] plus_pulse_out,
  output logic [1:0] minus_pulse_out,
  output logic [1:0] step_pulse_out,
  output logic [1:0] direction_out,
  output logic [1:0] driving_status_out,
  output logic [1:0] accelerating_out,
  output logic [1:0] decelerating_out,
  output logic [15:0] input_status_reg_a,
  output logic [15:0] input_status_reg_b,
  output logic [15:0] general_outputs
);
  localparam int PW = 32;
  localparam int SW = 13;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [PW-1:0] pins = {host_wr_i, in_position_in, ext_jog_minus_in, ext_jog_plus_in,
                        general_inputs, ~emergency_stop_in_n, servo_alarm_in,
                        limit_plus_minus_in, stop_inputs};
  logic [PW-1:0] s1;
  logic [PW-1:0] s2;
  logic [PW-1:0] s3;
  logic [PW-1:0] st;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      st <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < PW; i++) begin
        if (s2[i] == s3[i]) begin
          st[i] <= s3[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // reset sequencing and system clock
  // ----------------------------------------------------------------
  logic [3:0] rcnt;
  logic wbusy;
  logic [1:0] wcnt;
  logic wr_prev;
  mdsst_cmd_t cmd;
  logic [1:0] cax;
  logic [15:0] cdata;
  wire [3:0] next_rcnt = (rcnt == `MDSST_BUSY_RESET_CYC) ? rcnt : 4'(rcnt + 4'h1);
  wire sclk_run = (next_rcnt >= `MDSST_SCLK_START_CYC);
  wire tick = sclk_run & ~sclk_o;
  wire [1:0] next_wcnt = 2'(wcnt + 2'h1);
  wire release_evt = wbusy & tick & (next_wcnt == `MDSST_BUSY_WRITE_SCLK);
  wire host_take = st[PW-1] & ~wr_prev & busy_out_n;
  wire next_busy = (next_rcnt < `MDSST_BUSY_RESET_CYC) | (wbusy & ~release_evt) | host_take;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rcnt <= 4'h0;
      sclk_o <= 1'b0;
      busy_out_n <= 1'b0;
      busy_oe_o <= 1'b1;
      wbusy <= 1'b0;
      wcnt <= 2'h0;
      wr_prev <= 1'b0;
      cmd <= `MDSST_CMD_HOLD;
      cax <= 2'h0;
      cdata <= 16'h0000;
    end else begin
      rcnt <= next_rcnt;
      wr_prev <= st[PW-1];
      if (sclk_run) begin
        sclk_o <= ~sclk_o;
      end
      busy_out_n <= ~next_busy;
      busy_oe_o <= next_busy;
      if (host_take) begin
        wbusy <= 1'b1;
        wcnt <= 2'h0;
        cmd <= host_cmd_i;
        cax <= host_axis_i;
        cdata <= host_data_i;
      end else if (wbusy && tick) begin
        wcnt <= next_wcnt;
        if (release_evt) begin
          wbusy <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // stop input sampling and filters
  // ----------------------------------------------------------------
  logic [SW-1:0] act;
  logic [8:0] fcnt [SW];
  wire [8:0] thr = filter_enable_i ? (`MDSST_MIN_STOP_TICKS << filter_const_i)
                                   : `MDSST_MIN_STOP_TICKS;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      act <= '0;
      for (int i = 0; i < SW; i++) begin
        fcnt[i] <= 9'h000;
      end
    end else if (tick) begin
      for (int i = 0; i < SW; i++) begin
        if (!st[i]) begin
          fcnt[i] <= 9'h000;
          act[i] <= 1'b0;
        end else if (fcnt[i] != 9'h1ff) begin
          fcnt[i] <= 9'(fcnt[i] + 9'h001);
          act[i] <= (9'(fcnt[i] + 9'h001) >= thr);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode and hold
  // ----------------------------------------------------------------
  wire is_drive = (cmd <= `MDSST_CMD_CONT_MINUS);
  wire drive_evt = release_evt & is_drive;
  wire rel_cmd = release_evt & (cmd == `MDSST_CMD_RELEASE);
  wire dec_cmd = release_evt & (cmd == `MDSST_CMD_DECEL_STOP);
  wire sud_cmd = release_evt & (cmd == `MDSST_CMD_SUDDEN_STOP);
  wire out_cmd = release_evt & (cmd == `MDSST_CMD_WRITE_OUT);
  logic hold_on;
  logic [1:0] pend;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hold_on <= 1'b0;
      pend <= 2'h0;
    end else if (rel_cmd) begin
      hold_on <= 1'b0;
      pend <= 2'h0;
    end else begin
      if (release_evt && cmd == `MDSST_CMD_HOLD) begin
        hold_on <= 1'b1;
      end
      if (drive_evt && hold_on) begin
        pend <= pend | cax;
      end
    end
  end

  // ----------------------------------------------------------------
  // axis engines
  // ----------------------------------------------------------------
  mdsst_axis_if #(.CW(CW)) axi [2] ();

  for (genvar a = 0; a < 2; a++) begin : g_axis
    wire sel = cax[a];
    assign axi[a].tick = tick;
    assign axi[a].load = drive_evt & sel;
    assign axi[a].go = (drive_evt & sel & ~hold_on) | (rel_cmd & pend[a]);
    assign axi[a].dir_minus = cmd[0];
    assign axi[a].contin = cmd[1];
    assign axi[a].count = CW'(cdata);
    assign axi[a].half = (speed_half_i == 8'h00) ? 8'h01 : speed_half_i;
    assign axi[a].sudden = act[12] | (act[10+a] & alarm_enable_i[a]) | (sud_cmd & sel);
    assign axi[a].decel = (|(act[3*a +: 3] & stop_enable_i[3*a +: 3])) | (dec_cmd & sel);
    assign axi[a].lim = act[6+2*a +: 2];
    assign axi[a].lim_sudden = limit_sudden_i[a];

    mdsst_axis #(.CW(CW)) u_axis (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .ax(axi[a])
    );

    assign plus_pulse_out[a] = axi[a].pulse_p & ~step_mode_i;
    assign minus_pulse_out[a] = axi[a].pulse_m & ~step_mode_i;
    assign step_pulse_out[a] = axi[a].step & step_mode_i;
    assign direction_out[a] = axi[a].dir & step_mode_i;
    assign driving_status_out[a] = axi[a].driving;
    assign accelerating_out[a] = axi[a].accel;
    assign decelerating_out[a] = axi[a].decel_st;
  end

  // ----------------------------------------------------------------
  // status and general outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      input_status_reg_a <= 16'h0000;
      input_status_reg_b <= 16'h0000;
      general_outputs <= {2{`MDSST_OUT_DATA_RESET}};
    end else begin
      input_status_reg_a <= {2'h0, st[11], st[30], st[28], st[26], st[5:3],
                             st[10], st[29], st[27], st[25], st[2:0]};
      input_status_reg_b <= {4'h0, st[24:13]};
      if (out_cmd && cax[0]) begin
        general_outputs[7:0] <= cdata[7:0];
      end
      if (out_cmd && cax[1]) begin
        general_outputs[15:8] <= cdata[7:0];
      end
    end
  end
endmodule : mdsst_top

`default_nettype wire

// *** bench/mdsst_top_monitor.sv ***
// mdsst_top_monitor.sv: port timing assertions for mdsst_top
// assumes: bound to mdsst_top; counts in ref_clk_i edges, system clock = ref/2
`timescale 1ns/1ps
`default_nettype none

module mdsst_top_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic filter_enable_i,
  input wire logic emergency_stop_in_n,
  input wire logic sclk_o,
  input wire logic busy_out_n,
  input wire logic busy_oe_o,
  input wire logic [1:0] plus_pulse_out,
  input wire logic [1:0] minus_pulse_out,
  input wire logic [1:0] step_pulse_out,
  input wire logic [1:0] driving_status_out,
  input wire logic [1:0] accelerating_out,
  input wire logic [1:0] decelerating_out,
  input wire logic [15:0] general_outputs
);
  default clocking mon_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  wire logic pulse0 = plus_pulse_out[0] | minus_pulse_out[0] | step_pulse_out[0];

  chk_reset_levels: assert property ($fell(rst_i) |-> !sclk_o && !busy_out_n &&
    driving_status_out == 2'h0 && general_outputs == 16'h0000)
    else $error("outputs not at reset level");
  chk_sclk_start: assert property ($fell(rst_i) |-> ##[1:3] sclk_o)
    else $error("system clock late after reset");
  chk_sclk_run: assert property (sclk_o |=> !sclk_o)
    else $error("system clock not toggling");
  chk_busy_release: assert property ($fell(rst_i) |-> !busy_out_n [*7] ##[1:2] busy_out_n)
    else $error("busy width after reset wrong");
  chk_busy_write: assert property ($fell(busy_out_n) |-> ##[1:5] busy_out_n)
    else $error("busy too long after write");
  chk_busy_enable: assert property (busy_oe_o != busy_out_n)
    else $error("busy enable disagrees with busy");
  chk_drive_start: assert property ($rose(driving_status_out[0]) |-> $rose(busy_out_n))
    else $error("driving rose away from busy end");
  chk_first_pulse: assert property ($rose(driving_status_out[0]) |->
    !pulse0 [*5] ##[1:2] pulse0)
    else $error("first pulse not three system clocks after start");
  chk_accel_start: assert property ($rose(driving_status_out[0]) |->
    !accelerating_out[0] [*5] ##[1:2] accelerating_out[0])
    else $error("accel status not three system clocks after start");
  chk_status_end: assert property ($fell(driving_status_out[0]) |->
    !accelerating_out[0] && !decelerating_out[0] && !pulse0)
    else $error("status left active at drive end");
  chk_emg_stop: assert property ((!emergency_stop_in_n && !filter_enable_i) [*8] ##3
    !emergency_stop_in_n |-> driving_status_out == 2'h0 && !pulse0)
    else $error("emergency stop did not stop pulses");
  chk_gpo_busy: assert property (!$stable(general_outputs) |-> $rose(busy_out_n))
    else $error("general outputs changed outside a write");
  chk_status_sclk: assert property (!$stable({driving_status_out, accelerating_out,
    decelerating_out}) |-> $rose(sclk_o))
    else $error("status changed off a system clock rise");
endmodule : mdsst_top_monitor

bind mdsst_top mdsst_top_monitor i_mdsst_top_monitor (.ref_clk_i, .rst_i, .filter_enable_i,
  .emergency_stop_in_n, .sclk_o, .busy_out_n, .busy_oe_o, .plus_pulse_out, .minus_pulse_out,
  .step_pulse_out, .driving_status_out, .accelerating_out, .decelerating_out, .general_outputs);

`default_nettype wire

// *** bench/mdsst_partner.sv ***
// mdsst_partner.sv: machine side model, stop pins and an axis 0 pulse counter
// assumes: the bench calls hold_pin; pins idle at their inactive level
`timescale 1ns/1ps
`default_nettype none

module mdsst_partner (
  input wire logic ref_clk_i,
  input wire logic [1:0] plus_pulse_out,
  input wire logic [1:0] minus_pulse_out,
  input wire logic [1:0] step_pulse_out,
  output logic emergency_stop_in_n = 1'b1,
  output logic [1:0] servo_alarm_in = 2'h0,
  output logic [3:0] limit_plus_minus_in = 4'h0,
  output logic [5:0] stop_inputs = 6'h00
);
  int cnt = 0;
  int mcnt = 0;
  int run = 0;
  int hw = 0;
  logic p_q = 1'b0;
  wire logic p0 = plus_pulse_out[0] | minus_pulse_out[0] | step_pulse_out[0];

  // counts pulses, width of the last one
  always @(posedge ref_clk_i) begin
    p_q <= p0;
    run <= p0 ? run + 1 : 0;
    if (p0 && !p_q) cnt <= cnt + 1;
    if (p0 && !p_q && minus_pulse_out[0]) mcnt <= mcnt + 1;
    if (!p0 && p_q) hw <= run;
  end

  // one stop pin active for n edges, longer than a system clock unless a glitch is wanted
  task automatic hold_pin(input int sel, input int n);
    @(posedge ref_clk_i);
    case (sel)
      0: emergency_stop_in_n <= 1'b0;
      1: servo_alarm_in[0] <= 1'b1;
      2: limit_plus_minus_in[0] <= 1'b1;
      default: stop_inputs[0] <= 1'b1;
    endcase
    repeat (n) @(posedge ref_clk_i);
    emergency_stop_in_n <= 1'b1;
    servo_alarm_in <= 2'h0;
    limit_plus_minus_in <= 4'h0;
    stop_inputs <= 6'h00;
  endtask : hold_pin
endmodule : mdsst_partner

`default_nettype wire

// *** bench/mdsst_test.sv ***
// mdsst_test.sv: self-checking bench for mdsst_top with the machine side model
// assumes: package, design, partner and bound monitor compiled first
`timescale 1ns/1ps
`default_nettype none
`include "mdsst_regs.svh"

module mdsst_test
  import mdsst_pkg::*;
;
  typedef struct packed {
    logic sm;
    mdsst_cmd_t cmd;
    logic [15:0] cnt;
    logic [7:0] half;
    logic [15:0] expn;
  } mdsst_row_s;
  mdsst_row_s rows [4] = '{'{1'b1, 4'h0, 16'h0003, 8'h01, 16'h0003},
    '{1'b1, 4'h1, 16'h0005, 8'h02, 16'h0005}, '{1'b0, 4'h0, 16'h0000, 8'h01, 16'h0001},
    '{1'b0, 4'h1, 16'h0002, 8'h03, 16'h0002}};
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic host_wr_i = 1'b0;
  logic [1:0] host_axis_i = 2'h0;
  mdsst_cmd_t host_cmd_i = 4'h0;
  logic [15:0] host_data_i = 16'h0000;
  logic [7:0] speed_half_i = 8'h01;
  logic step_mode_i = 1'b0, filter_enable_i = 1'b0, seen_dec = 1'b0;
  logic [1:0] limit_sudden_i = 2'h0, alarm_enable_i = 2'h0, ext_jog_plus_in = 2'h0;
  logic [1:0] ext_jog_minus_in = 2'h0, in_position_in = 2'h0;
  logic [5:0] stop_enable_i = 6'h00;
  logic [2:0] filter_const_i = 3'h0;
  logic [11:0] general_inputs = 12'h000;
  logic dirs [4];
  wire logic emergency_stop_in_n, sclk_o, busy_out_n, busy_oe_o;
  wire logic [1:0] servo_alarm_in, plus_pulse_out, minus_pulse_out, step_pulse_out;
  wire logic [1:0] direction_out, driving_status_out, accelerating_out, decelerating_out;
  wire logic [3:0] limit_plus_minus_in;
  wire logic [5:0] stop_inputs;
  wire logic [15:0] input_status_reg_a, input_status_reg_b, general_outputs;
  int miscompares = 0, check_count = 0, cycles = 0, c0, m0;

  mdsst_top i_mdsst_top (.ref_clk_i, .rst_i, .host_wr_i, .host_axis_i, .host_cmd_i,
    .host_data_i, .speed_half_i, .step_mode_i, .limit_sudden_i, .stop_enable_i,
    .alarm_enable_i, .filter_enable_i, .filter_const_i, .emergency_stop_in_n,
    .limit_plus_minus_in, .servo_alarm_in, .stop_inputs, .general_inputs, .ext_jog_plus_in,
    .ext_jog_minus_in, .in_position_in, .sclk_o, .busy_out_n, .busy_oe_o, .plus_pulse_out,
    .minus_pulse_out, .step_pulse_out, .direction_out, .driving_status_out,
    .accelerating_out, .decelerating_out, .input_status_reg_a, .input_status_reg_b,
    .general_outputs);
  mdsst_partner i_mdsst_partner (.ref_clk_i, .plus_pulse_out, .minus_pulse_out,
    .step_pulse_out, .emergency_stop_in_n, .servo_alarm_in, .limit_plus_minus_in,
    .stop_inputs);

  always #20 ref_clk_i = ~ref_clk_i;

  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (decelerating_out[0] === 1'b1) seen_dec <= 1'b1;
    else if (host_wr_i) seen_dec <= 1'b0;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy_out_n !== lvl && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("busy", 16'(busy_out_n), 16'(lvl));
  endtask : wait_busy

  task automatic wait_end(input int lim);
    int n;
    n = 0;
    while (driving_status_out[0] !== 1'b0 && n < lim) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("drive end", 16'(n < lim), 16'h1);
  endtask : wait_end

  // host holds the write until busy answers, then drops it
  task automatic wr(input logic [1:0] ax, input mdsst_cmd_t cmd, input logic [15:0] d);
    @(posedge ref_clk_i);
    host_axis_i <= ax;
    host_cmd_i <= cmd;
    host_data_i <= d;
    host_wr_i <= 1'b1;
    wait_busy(1'b0);
    @(posedge ref_clk_i);
    host_wr_i <= 1'b0;
    wait_busy(1'b1);
    repeat (3) @(posedge ref_clk_i);
  endtask : wr

  initial begin
    int i;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wait_busy(1'b1);
    for (i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      step_mode_i <= rows[i].sm;
      speed_half_i <= rows[i].half;
      c0 = i_mdsst_partner.cnt;
      m0 = i_mdsst_partner.mcnt;
      wr(2'h1, rows[i].cmd, rows[i].cnt);
      dirs[i] = direction_out[0];
      wait_end(400);
      chk("pulses", 16'(i_mdsst_partner.cnt - c0), rows[i].expn);
      chk("minus pulses", 16'(i_mdsst_partner.mcnt - m0),
        (!rows[i].sm && rows[i].cmd == `MDSST_CMD_FIX_MINUS) ? rows[i].expn : 16'h0000);
      chk("pulse width", 16'(i_mdsst_partner.hw), 16'(2 * rows[i].half));
    end
    chk("dir sense", 16'(dirs[0] ^ dirs[1]), 16'h0001);
    chk("dir gated", 16'(dirs[2]), 16'h0000);
    $display("test drive table done");
    @(posedge ref_clk_i);
    general_inputs <= 12'ha5c;
    ext_jog_plus_in <= 2'h1;
    in_position_in <= 2'h2;
    repeat (6) @(negedge ref_clk_i);
    chk("status b", input_status_reg_b, 16'h0a5c);
    chk("status a", input_status_reg_a, 16'h1008);
    wr(2'h3, `MDSST_CMD_WRITE_OUT, 16'h00a5);
    chk("outputs", general_outputs, 16'ha5a5);
    wr(2'h1, `MDSST_CMD_WRITE_OUT, 16'h003c);
    chk("outputs", general_outputs, 16'ha53c);
    $display("test pins and outputs done");
    @(posedge ref_clk_i);
    alarm_enable_i <= 2'h3;
    limit_sudden_i <= 2'h1;
    stop_enable_i <= 6'h01;
    // sources: emergency, alarm, limit, stop pin, sudden cmd, decel cmd
    for (i = 0; i < 6; i++) begin
      wr(2'h1, `MDSST_CMD_CONT_PLUS, 16'h0000);
      repeat (20) @(negedge ref_clk_i);
      if (i == 0) begin
        i_mdsst_partner.hold_pin(0, 1);
        repeat (8) @(negedge ref_clk_i);
        chk("glitch ignored", 16'(driving_status_out[0]), 16'h0001);
      end
      if (i == 4) wr(2'h1, `MDSST_CMD_SUDDEN_STOP, 16'h0000);
      else if (i == 5) wr(2'h1, `MDSST_CMD_DECEL_STOP, 16'h0000);
      else i_mdsst_partner.hold_pin(i, 12);
      if (i == 3 || i == 5) begin
        wait_end(400);
        chk("decel seen", 16'(seen_dec), 16'h0001);
      end else begin
        c0 = i_mdsst_partner.cnt;
        repeat (4) @(negedge ref_clk_i);
        chk("sudden stop", 16'(driving_status_out[0]), 16'h0000);
        chk("no pulse", 16'(i_mdsst_partner.cnt - c0), 16'h0000);
      end
    end
    $display("test stops done");
    @(posedge ref_clk_i);
    filter_enable_i <= 1'b1;
    filter_const_i <= 3'h2;
    wr(2'h1, `MDSST_CMD_CONT_PLUS, 16'h0000);
    i_mdsst_partner.hold_pin(1, 8);
    repeat (8) @(negedge ref_clk_i);
    chk("filtered", 16'(driving_status_out[0]), 16'h0001);
    i_mdsst_partner.hold_pin(1, 40);
    repeat (4) @(negedge ref_clk_i);
    chk("filter stop", 16'(driving_status_out[0]), 16'h0000);
    @(posedge ref_clk_i);
    filter_enable_i <= 1'b0;
    $display("test filter done");
    wr(2'h3, `MDSST_CMD_HOLD, 16'h0000);
    wr(2'h3, `MDSST_CMD_FIX_PLUS, 16'h0004);
    chk("held", 16'(driving_status_out), 16'h0000);
    c0 = i_mdsst_partner.cnt;
    wr(2'h3, `MDSST_CMD_RELEASE, 16'h0000);
    chk("released", 16'(driving_status_out), 16'h0003);
    wait_end(400);
    chk("released pulses", 16'(i_mdsst_partner.cnt - c0), 16'h0004);
    $display("test hold release done");
    wr(2'h3, `MDSST_CMD_CONT_PLUS, 16'h0000);
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("reset levels", {driving_status_out, busy_out_n, sclk_o, general_outputs[11:0]},
      16'h0000);
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wait_busy(1'b1);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : mdsst_test

`default_nettype wire
